// *** logic/ivo_video_out.sv ***
// Interlaced video output ports: flags, DIN capture, parallel and serial outputs
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - The serial port is enabled after reset and runs only while the serial enable pin is high.
// - Setting the serial port disable bit switches the serial output off regardless of the pin.
// - Standby switches the serial output off whatever the pin and the disable bit say.
// - Every serial packet is twelve bits with a one start bit first and a zero stop bit last.
// - The video byte follows the start bit least significant bit first in packet bits 1 to 8.
// - Line valid goes in packet bit 9 and frame valid in bit 10, before the stop bit.
// - The packet holds the interlaced byte (the parallel output byte unless raw progressive is on) with the current line and frame valid outputs.
// - The shift clock runs at twelve times the master clock rate.
// - The serial port carries only the interlaced byte stream of the parallel interlaced path.
// - In 525-line mode the field and vertical flags follow the 525-line line table.
// - In 625-line mode the flags follow the 625-line table and EAV carries H=1, SAV H=0.
// - Progressive raw output on the parallel port is allowed only in stand-alone mode.
// - The outside source supplies proper BT.656 bytes that are muxed into the output stream.
// - Input data is sampled by the input port clock when clock select is one, else by master.
// - Software picks the rising or falling edge of the chosen sampling clock.
// - In standby frame and line valid are low, pixel clock is high and data is zero.
module ivo_video_out (
    // Clock, reset, enable (clk_sys_in is the 12x shift clock)
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Internal video source
    input wire logic [7:0] video_byte_in,
    input wire logic line_valid_in,
    input wire logic frame_valid_in,
    input wire logic line_start_in,
    input wire logic [7:0] raw_pixel_in,
    // External parallel input
    input wire logic [7:0] din_byte_in,
    input wire logic din_clk_in,
    // Board pins
    input wire logic serial_port_enable_pin_in,
    input wire logic standby_in,
    // Parallel output
    output logic [7:0] dout_out,
    output logic line_valid_flag_out,
    output logic frame_valid_flag_out,
    output logic pixel_clock_out,
    output logic field_out,
    output logic vblank_out,
    output logic [7:0] eav_code_out,
    output logic [7:0] sav_code_out,
    // Serial pair
    output logic serial_pair_positive_out,
    output logic serial_pair_negative_out
);
    import ivo_pkg::*;

    // BT.656 timing code: 1 F V H P3 P2 P1 P0
    function automatic logic [7:0] tcode(input logic f, input logic v, input logic h);
        tcode = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction : tcode
    // Field and vertical flags for a line number, {F,V}
    function automatic logic [1:0] line_flags(input logic [9:0] n, input logic pal);
        line_flags = 2'b00;
        if (pal) begin
            if (n <= L625_A) line_flags = 2'b01;
            else if (n <= L625_B) line_flags = 2'b00;
            else if (n <= L625_C) line_flags = 2'b01;
            else if (n <= L625_D) line_flags = 2'b11;
            else if (n <= L625_E) line_flags = 2'b10;
            else line_flags = 2'b11;
        end else begin
            if (n <= L525_A) line_flags = 2'b11;
            else if (n <= L525_B) line_flags = 2'b01;
            else if (n <= L525_C) line_flags = 2'b00;
            else if (n <= L525_D) line_flags = 2'b00;
            else if (n <= L525_E) line_flags = 2'b01;
            else if (n <= L525_F) line_flags = 2'b11;
            else line_flags = 2'b10;
        end
    endfunction : line_flags
    // APB and control register
    logic [IVO_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    // Timing and capture
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [9:0] line_q, line_d;
    logic pix_div_q, pix_div_d;
    logic din_clk_prev_q, din_clk_prev_d;
    logic [7:0] din_cap_q, din_cap_d;
    // Output stage
    logic [7:0] dout_q, dout_d;
    logic lv_q, lv_d, fv_q, fv_d;
    logic pclk_q, pclk_d;
    logic field_q, field_d, vbl_q, vbl_d;
    logic [7:0] eav_q, eav_d, sav_q, sav_d;
    logic [IVO_PKT_W-1:0] pkt_q, pkt_d;
    logic ser_pos_q, ser_pos_d, ser_neg_q, ser_neg_d;
    logic master_tick, half_tick, acc, wr_now, mapped;
    logic ser_active, prog_ok, din_edge;
    logic [1:0] fvflag;
    logic [7:0] il_byte;
    assign master_tick = (bit_cnt_q == IVO_LAST_BIT);
    assign half_tick = (bit_cnt_q == IVO_HALF_BIT);
    assign acc = psel_in && penable_in;
    assign wr_now = acc && pready_q && pwrite_in && !pslverr_q;
    assign mapped = (paddr_in == IVO_CTRL_OFS) || (paddr_in == IVO_STAT_OFS) ||
                    (paddr_in == IVO_LINE_OFS);
    // Pin must be held, disable bit clear and no standby
    assign ser_active = serial_port_enable_pin_in && !ctrl_q[IVO_SER_DIS_BIT] &&
                        !standby_in;
    // Raw progressive path needs stand-alone mode: the colour pipe cannot do it
    assign prog_ok = ctrl_q[IVO_PROG_BIT] && ctrl_q[IVO_STANDALONE_BIT];
    // Input clock pin is synchronous, so a registered copy finds its edges
    assign din_edge = ctrl_q[IVO_EDGE_SEL_BIT] ? (din_clk_prev_q && !din_clk_in) :
                      (!din_clk_prev_q && din_clk_in);
    assign fvflag = line_flags(line_q, ctrl_q[IVO_PAL_BIT]);
    // External bytes replace the internal stream when the mux bit is set
    assign il_byte = ctrl_q[IVO_DIN_MUX_BIT] ? din_cap_q : video_byte_in;

    // APB slave: one wait state, write lands on the edge where pready is seen
    always_comb begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (acc && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = !mapped;
            prdata_d = 32'h0000_0000;
            if (!pwrite_in) begin
                if (paddr_in == IVO_CTRL_OFS) begin
                    prdata_d[IVO_CTRL_W-1:0] = ctrl_q;
                end else if (paddr_in == IVO_STAT_OFS) begin
                    prdata_d[IVO_ST_SER_ACT] = ser_active;
                    prdata_d[IVO_ST_FIELD] = field_q;
                    prdata_d[IVO_ST_VBLANK] = vbl_q;
                    prdata_d[IVO_ST_STANDBY] = standby_in;
                end else if (paddr_in == IVO_LINE_OFS) begin
                    prdata_d[9:0] = line_q;
                end
            end
        end
        if (wr_now && paddr_in == IVO_CTRL_OFS) begin
            ctrl_d = pwdata_in[IVO_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ctrl_q <= IVO_CTRL_RST;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (clk_en_in) begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end
    // Master clock phase, line counter and input capture
    always_comb begin
        bit_cnt_d = master_tick ? 4'h0 : bit_cnt_q + 4'h1;
        line_d = line_q;
        pix_div_d = pix_div_q;
        din_clk_prev_d = din_clk_in;
        din_cap_d = din_cap_q;
        if (master_tick) begin
            pix_div_d = !pix_div_q;
            if (line_start_in) begin
                line_d = (line_q >= (ctrl_q[IVO_PAL_BIT] ? L625_END : L525_END)) ?
                         LINE_FIRST : line_q + 10'd1;
            end
        end
        if (ctrl_q[IVO_CLK_SEL_BIT]) begin
            if (din_edge) din_cap_d = din_byte_in;
        end else if (ctrl_q[IVO_EDGE_SEL_BIT] ? half_tick : master_tick) begin
            din_cap_d = din_byte_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            bit_cnt_q <= 4'h0;
            line_q <= LINE_FIRST;
            pix_div_q <= 1'b0;
            din_clk_prev_q <= 1'b0;
            din_cap_q <= 8'h00;
        end else if (clk_en_in) begin
            bit_cnt_q <= bit_cnt_d;
            line_q <= line_d;
            pix_div_q <= pix_div_d;
            din_clk_prev_q <= din_clk_prev_d;
            din_cap_q <= din_cap_d;
        end
    end
    // Output stage: parallel port, timing codes, serializer
    always_comb begin
        dout_d = dout_q;
        lv_d = lv_q;
        fv_d = fv_q;
        pkt_d = pkt_q;
        field_d = fvflag[1];
        vbl_d = fvflag[0];
        eav_d = tcode(fvflag[1], fvflag[0], 1'b1);
        sav_d = tcode(fvflag[1], fvflag[0], 1'b0);
        // Raw progressive pixel clock runs at half the master rate
        pclk_d = prog_ok ? !pix_div_q : (bit_cnt_q < IVO_HALF_BIT);
        if (master_tick) begin
            // Flags see standby here so the packet flags match the flag pins
            lv_d = line_valid_in && !standby_in;
            fv_d = frame_valid_in && !standby_in;
            dout_d = prog_ok ? raw_pixel_in : il_byte;
            // Serial always takes the interlaced byte, even when parallel is raw
            pkt_d = {IVO_STOP_VAL, fv_d, lv_d,
                     il_byte, IVO_START_VAL};
        end
        if (standby_in) begin
            dout_d = 8'h00;
            lv_d = 1'b0;
            fv_d = 1'b0;
            pclk_d = 1'b1;
        end
        // Bit index equals the shift phase, so packets abut with no idle bits
        ser_pos_d = ser_active ? pkt_q[bit_cnt_q] : 1'b0;
        ser_neg_d = ser_active ? !pkt_q[bit_cnt_q] : 1'b0;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            dout_q <= 8'h00;
            lv_q <= 1'b0;
            fv_q <= 1'b0;
            pclk_q <= 1'b1;
            field_q <= 1'b0;
            vbl_q <= 1'b0;
            eav_q <= 8'h00;
            sav_q <= 8'h00;
            pkt_q <= '0;
            ser_pos_q <= 1'b0;
            ser_neg_q <= 1'b0;
        end else if (clk_en_in) begin
            dout_q <= dout_d;
            lv_q <= lv_d;
            fv_q <= fv_d;
            pclk_q <= pclk_d;
            field_q <= field_d;
            vbl_q <= vbl_d;
            eav_q <= eav_d;
            sav_q <= sav_d;
            pkt_q <= pkt_d;
            ser_pos_q <= ser_pos_d;
            ser_neg_q <= ser_neg_d;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign dout_out = dout_q;
    assign line_valid_flag_out = lv_q;
    assign frame_valid_flag_out = fv_q;
    assign pixel_clock_out = pclk_q;
    assign field_out = field_q;
    assign vblank_out = vbl_q;
    assign eav_code_out = eav_q;
    assign sav_code_out = sav_q;
    assign serial_pair_positive_out = ser_pos_q;
    assign serial_pair_negative_out = ser_neg_q;

    property p_ser_off_no_pin;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && !serial_port_enable_pin_in) |=> !ser_pos_q && !ser_neg_q;
    endproperty
    a_ser_off_no_pin: assert property (p_ser_off_no_pin) else $error("pair on, pin low");
    property p_ser_off_dis;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && ctrl_q[IVO_SER_DIS_BIT]) |=> !ser_pos_q && !ser_neg_q;
    endproperty
    a_ser_off_dis: assert property (p_ser_off_dis) else $error("pair on while disabled");
    property p_ser_off_stby;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && standby_in) |=> !ser_pos_q && !ser_neg_q;
    endproperty
    a_ser_off_stby: assert property (p_ser_off_stby) else $error("serial on in standby");
    property p_pkt_frame;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && master_tick) |=> pkt_q[0] && !pkt_q[IVO_PKT_W-1];
    endproperty
    a_pkt_frame: assert property (p_pkt_frame) else $error("bad start or stop bit");
    property p_pkt_byte;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && master_tick && !standby_in && !prog_ok) |=> pkt_q[8:1] == dout_q;
    endproperty
    a_pkt_byte: assert property (p_pkt_byte) else $error("packet byte differs");
    property p_pkt_flags;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && master_tick) |=> pkt_q[10:9] == {fv_q, lv_q};
    endproperty
    a_pkt_flags: assert property (p_pkt_flags) else $error("packet flags differ");
    property p_period;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && master_tick) |-> ##1 (bit_cnt_q == 4'h0);
    endproperty
    a_period: assert property (p_period) else $error("shift phase not twelve");
    property p_stby_out;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && standby_in) |=> !lv_q && !fv_q && pclk_q && dout_q == 8'h00;
    endproperty
    a_stby_out: assert property (p_stby_out) else $error("standby outputs wrong");
    property p_sav_h;
        @(posedge clk_sys_in) disable iff (reset_in)
        !sav_q[4] && (eav_q == 8'h00 || eav_q[4]);
    endproperty
    a_sav_h: assert property (p_sav_h) else $error("H bit wrong");
    property p_ser_diff;
        @(posedge clk_sys_in) disable iff (reset_in)
        (clk_en_in && ser_active) |=> ser_pos_q != ser_neg_q;
    endproperty
    a_ser_diff: assert property (p_ser_diff) else $error("pair not complementary");
    c_packet: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        ser_active && master_tick ##1 ser_active [*8]);
    c_stby: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        $rose(standby_in));
    c_wrap: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        line_q == LINE_FIRST && $past(line_q) != LINE_FIRST);
endmodule : ivo_video_out

`default_nettype wire

// *** logic/ivo_pkg.sv ***
// Constants shared by the interlaced video output port logic
package ivo_pkg;
    // Register map (byte addresses)
    localparam logic [11:0] IVO_CTRL_OFS = 12'h000;
    localparam logic [11:0] IVO_STAT_OFS = 12'h004;
    localparam logic [11:0] IVO_LINE_OFS = 12'h008;
    // Control field positions
    localparam int IVO_SER_DIS_BIT = 0;
    localparam int IVO_CLK_SEL_BIT = 1;
    localparam int IVO_EDGE_SEL_BIT = 2;
    localparam int IVO_PAL_BIT = 3;
    localparam int IVO_STANDALONE_BIT = 4;
    localparam int IVO_PROG_BIT = 5;
    localparam int IVO_DIN_MUX_BIT = 6;
    localparam int IVO_CTRL_W = 7;
    localparam logic [6:0] IVO_CTRL_RST = 7'h00;
    // Status field positions
    localparam int IVO_ST_SER_ACT = 0;
    localparam int IVO_ST_FIELD = 1;
    localparam int IVO_ST_VBLANK = 2;
    localparam int IVO_ST_STANDBY = 3;
    // Serial packet layout
    localparam int IVO_PKT_W = 12;
    localparam int IVO_MCLK_HZ = 27_000_000;
    localparam int IVO_SHIFT_HZ = 324_000_000;
    localparam int IVO_BIT_DIV = IVO_SHIFT_HZ / IVO_MCLK_HZ;
    localparam logic [3:0] IVO_LAST_BIT = 4'(IVO_BIT_DIV - 1);
    localparam logic [3:0] IVO_HALF_BIT = 4'(IVO_BIT_DIV / 2);
    localparam logic IVO_START_VAL = 1'b1;
    localparam logic IVO_STOP_VAL = 1'b0;
    // 525-line flag boundaries (last line of each span)
    localparam logic [9:0] L525_A = 10'd3;
    localparam logic [9:0] L525_B = 10'd9;
    localparam logic [9:0] L525_C = 10'd19;
    localparam logic [9:0] L525_D = 10'd263;
    localparam logic [9:0] L525_E = 10'd265;
    localparam logic [9:0] L525_F = 10'd282;
    localparam logic [9:0] L525_END = 10'd525;
    // 625-line flag boundaries
    localparam logic [9:0] L625_A = 10'd22;
    localparam logic [9:0] L625_B = 10'd310;
    localparam logic [9:0] L625_C = 10'd312;
    localparam logic [9:0] L625_D = 10'd335;
    localparam logic [9:0] L625_E = 10'd623;
    localparam logic [9:0] L625_END = 10'd625;
    localparam logic [9:0] LINE_FIRST = 10'd1;
endpackage : ivo_pkg

// *** test/ivo_deser_model.sv ***
// Serial receiver model that frames the twelve-bit packets of the video port
`timescale 1ns/10ps
`default_nettype none
module ivo_deser_model (
    // Clock and reset of the port
    input wire logic clk_in,
    input wire logic reset_in,
    // Differential pair
    input wire logic pos_in,
    input wire logic neg_in,
    // Received packets
    output logic [11:0] pkt_out,
    output int pkt_cnt_out,
    output int err_cnt_out
);
    int cyc;
    logic [11:0] sh;
    logic full;
    logic act;
    assign act = pos_in | neg_in;
    // Framing follows the bit phase counted from reset release, as a
    // clock-forwarded receiver would; a partial packet is dropped.
    always @(posedge clk_in) begin
        if (reset_in) begin
            cyc <= 0;
            full <= 1'b0;
            pkt_cnt_out <= 0;
            err_cnt_out <= 0;
        end else begin
            cyc <= cyc + 1;
            sh[(cyc + 11) % 12] <= pos_in;
            if (cyc % 12 == 1) begin
                full <= act;
            end else if (!act) begin
                full <= 1'b0;
            end
            if (pos_in && neg_in) begin
                err_cnt_out <= err_cnt_out + 1;
            end
            if (cyc % 12 == 0 && full && act) begin
                pkt_out <= {pos_in, sh[10:0]};
                pkt_cnt_out <= pkt_cnt_out + 1;
                if (sh[0] !== 1'b1 || pos_in !== 1'b0) begin
                    err_cnt_out <= err_cnt_out + 1;
                end
            end
        end
    end
endmodule : ivo_deser_model
`default_nettype wire

// *** test/interlaced_video_output_ports_test.sv ***
// Register-driven bench for the interlaced video output ports
`timescale 1ns/10ps
`default_nettype none
module interlaced_video_output_ports_test;
    import ivo_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ls = 1'b0;
    logic lval = 1'b0, fval = 1'b0, dclk = 1'b0, pin = 1'b0, sby = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [7:0] vb = 8'h00, raw = 8'h00, din = 8'h00, dout, eav, sav;
    logic [7:0] tbl [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
    logic prdy, perr, rerr, lval_o, fval_o, pclk, fld, vbl, pos, neg;
    logic [11:0] pkt;
    int pcnt, ecnt, miscompares = 0, total_checks = 0, cycles = 0;
    always #25 clk = ~clk;
    ivo_video_out u_dut (.clk_sys_in(clk), .reset_in(rst), .clk_en_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr),
        .video_byte_in(vb), .line_valid_in(lval), .frame_valid_in(fval),
        .line_start_in(ls), .raw_pixel_in(raw), .din_byte_in(din), .din_clk_in(dclk),
        .serial_port_enable_pin_in(pin), .standby_in(sby), .dout_out(dout),
        .line_valid_flag_out(lval_o), .frame_valid_flag_out(fval_o),
        .pixel_clock_out(pclk), .field_out(fld), .vblank_out(vbl), .eav_code_out(eav),
        .sav_code_out(sav), .serial_pair_positive_out(pos), .serial_pair_negative_out(neg));
    ivo_deser_model u_rx (.clk_in(clk), .reset_in(rst), .pos_in(pos), .neg_in(neg),
        .pkt_out(pkt), .pkt_cnt_out(pcnt), .err_cnt_out(ecnt));
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // Ceiling covers both full line tables with margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request stands until the edge that samples pready high; answer taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        rdata = prdata;
        rerr = perr;
        chk("pready_wait", n, 32'h1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, e);
    endtask : rd
    task w8(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : w8
    task pkts;
        int n, c;
        repeat (3) begin
            c = pcnt;
            n = 0;
            while (pcnt == c && n < 40) begin
                @(negedge clk);
                n++;
            end
        end
    endtask : pkts
    // High for twelve edges spans exactly one master tick
    task step;
        @(posedge clk);
        ls <= 1'b1;
        repeat (12) @(posedge clk);
        ls <= 1'b0;
    endtask : step
    function automatic logic [1:0] flag_exp(input logic pal, input int ln);
        if (!pal) begin
            return ln <= 3 ? 2'h3 : ln <= 9 ? 2'h1 : ln <= 263 ? 2'h0 : ln <= 265 ? 2'h1 :
                ln <= 282 ? 2'h3 : 2'h2;
        end
        return ln <= 22 ? 2'h1 : ln <= 310 ? 2'h0 : ln <= 312 ? 2'h1 : ln <= 335 ? 2'h3 :
            ln <= 623 ? 2'h2 : 2'h3;
    endfunction : flag_exp
    function automatic logic [7:0] code(input logic f, input logic v, input logic h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction : code
    initial begin
        logic [1:0] x;
        int k;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(IVO_CTRL_OFS, 32'h0, "ctrl_rst");
        rd(IVO_STAT_OFS, 32'h6, "stat_rst");
        rd(IVO_LINE_OFS, 32'h1, "line_rst");
        apb(1'b0, 12'h00C, 32'h0);
        chk("slverr", rerr, 1'b1);
        w8(24);
        chk("pair_off", {pos, neg}, 2'b00);
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            pin <= 1'b1;
            vb <= tbl[k];
            lval <= k[0];
            fval <= k[1];
            pkts();
            chk("pkt", pkt, {1'b0, fval, lval, vb, 1'b1});
            chk("dout", {fval_o, lval_o, dout}, {fval, lval, vb});
        end
        rd(IVO_STAT_OFS, 32'h7, "stat_on");
        $display("test packets done");
        @(posedge clk);
        raw <= 8'hC5;
        apb(1'b1, IVO_CTRL_OFS, 32'h20);
        w8(36);
        chk("dout_prog", dout, vb);
        apb(1'b1, IVO_CTRL_OFS, 32'h30);
        pkts();
        chk("dout_raw", dout, 8'hC5);
        chk("pkt_ilace", pkt[8:1], vb);
        $display("test progressive done");
        @(posedge clk);
        din <= 8'h5A;
        apb(1'b1, IVO_CTRL_OFS, 32'h40);
        w8(36);
        chk("din_rise", dout, 8'h5A);
        apb(1'b1, IVO_CTRL_OFS, 32'h44);
        @(posedge clk);
        din <= 8'h77;
        w8(36);
        chk("din_fall", dout, 8'h77);
        apb(1'b1, IVO_CTRL_OFS, 32'h42);
        @(posedge clk);
        din <= 8'hC3;
        w8(36);
        chk("din_noedge", dout, 8'h77);
        @(posedge clk);
        dclk <= 1'b1;
        w8(36);
        chk("din_pclk_rise", dout, 8'hC3);
        apb(1'b1, IVO_CTRL_OFS, 32'h46);
        @(posedge clk);
        din <= 8'h99;
        dclk <= 1'b0;
        w8(36);
        chk("din_pclk_fall", dout, 8'h99);
        @(posedge clk);
        din <= 8'h11;
        dclk <= 1'b1;
        w8(36);
        chk("din_rise_ign", dout, 8'h99);
        $display("test input port done");
        for (k = 0; k < 2; k++) begin
            apb(1'b1, IVO_CTRL_OFS, {28'h0, k[0], 3'h0});
            for (int ln = 1; ln <= (k == 1 ? 625 : 525); ln++) begin
                w8(24);
                x = flag_exp(k[0], ln);
                chk("field_vert", {fld, vbl}, x);
                chk("eav", eav, code(x[1], x[0], 1'b1));
                chk("sav", sav, code(x[1], x[0], 1'b0));
                step();
            end
            rd(IVO_LINE_OFS, 32'h1, "line_wrap");
        end
        $display("test line tables done");
        apb(1'b1, IVO_CTRL_OFS, 32'h09);
        w8(3);
        chk("pair_dis", {pos, neg}, 2'b00);
        rd(IVO_STAT_OFS, 32'h4, "stat_dis");
        apb(1'b1, IVO_CTRL_OFS, 32'h08);
        @(posedge clk);
        sby <= 1'b1;
        w8(24);
        chk("standby", {pos, neg, dout, lval_o, fval_o, pclk}, 13'h0001);
        rd(IVO_STAT_OFS, 32'hC, "stat_sby");
        chk("rx_errors", ecnt, 32'h0);
        chk("rx_packets", pcnt > 0, 1'b1);
        $display("test disable and standby done");
        wrap_up();
    end
endmodule : interlaced_video_output_ports_test
`default_nettype wire
